/* File: inc/gtc_pkg.sv */
// Purpose: Types for the pin-read and timeout command block.
// Assumes: Constants come from gtc_regs.svh.
// Notes:   All module state is carried in the structs below.
`default_nettype none
package gtc_pkg;

   typedef enum logic [2:0] {
      GTC_IDLE,
      GTC_PARAM,
      GTC_SAMPLE,
      GTC_SEND_DATA,
      GTC_SEND_CRC_LO,
      GTC_SEND_CRC_HI,
      GTC_DONE
   } gtc_state_t;

   typedef struct packed {
      logic alt_detect_pin;
      logic gpio_pin_c;
      logic gpio_pin_b;
      logic gpio_pin_a;
   } gtc_pins_t;

   typedef struct packed {
      gtc_state_t  st;
      logic [7:0]  cmd;
      logic [15:0] crc;
      logic [7:0]  tend;
      logic [7:0]  txb;
      logic [3:0]  settle;
      logic        buf_en;
   } gtc_core_t;

   typedef struct packed {
      logic [15:0] pre;
      logic [7:0]  ticks;
      logic        expired;
   } gtc_tmr_t;

endpackage
`default_nettype wire

/* File: inc/gtc_regs.svh */
// Purpose: Constants for the pin-read and timeout command block.
// Assumes: 100 MHz system clock.
// Notes:   Shared by the command, timer and bench files through a guarded include.
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH

`define GTC_CMD_GPIO_READ   8'h77
`define GTC_CMD_TEND_WRITE  8'h88
`define GTC_CMD_TEND_READ   8'h99
`define GTC_TEND_RESET      8'hFF
`define GTC_TEND_REJECT     8'h00
`define GTC_CRC_POLY_REFL   16'hA001
`define GTC_CRC_SEED        16'h0000
`define GTC_GPIO_A_BIT      0
`define GTC_GPIO_B_BIT      1
`define GTC_GPIO_C_BIT      2
`define GTC_TICK_NS         100000
`define GTC_CLK_NS          10
`define GTC_TICK_CYC        (`GTC_TICK_NS / `GTC_CLK_NS)
`define GTC_SETTLE_CYC      4'h2

`endif

/* File: logic/gtc_cmd.sv */
// Purpose: Device commands for pin read and timeout end count write and read.
// Assumes: The link layer delivers bytes after reset, presence and ROM select.
// Notes:   Responses are handed out one byte at a time on the tx handshake.
//
// Overview of operation
// (R1) Command 77h with no parameter samples three pins and returns one byte.
// (R2) Pin A and B levels are valid only while the logic supply is powered.
// (R3) Pin C level is valid only while the parasite supply is active.
// (R4) A pin whose supply is off reads as one.
// (R5) Pin input buffers stay off except briefly around the sampling instant.
// (R6) Byte holds A, B, C in bits 0-2, bit 3 zero, upper nibble complemented.
// (R7) With the detect function selected, the pin C bit shows the detect pin.
// (R8) Pin byte is followed by inverted CRC-16 over command and pin byte.
// (R9) Host frames reset, presence, ROM select, command, data, then reset.
// (R10) Command 88h takes one parameter byte, stored as the timer end count.
// (R11) The stored end count sets the arbitration timer duration.
// (R12) A zero parameter is rejected: value kept, no CRC sent.
// (R13) The end count register resets to FFh.
// (R14) Timer duration is end count times 100 us.
// (R15) A valid write is answered with inverted CRC-16 over command and parameter.
// (R16) Command 99h returns the stored end count.
// (R17) The end count byte is followed by inverted CRC-16 over command and value.
// (R18) CRC-16 is x16+x15+x2+1, zero seed, LSB first, sent inverted low byte first.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_regs.svh"

module gtc_cmd
   import gtc_pkg::*;
#(
   parameter int TICK_CYC = `GTC_TICK_CYC
) (
   input  wire logic       clk_sys,            // System clock.
   input  wire logic       sys_rst,            // Synchronous reset.
   input  wire logic       clk_en,             // Freezes state while low.
   input  wire logic       link_reset,         // Link reset seen, frame restarts.
   input  wire logic       rx_valid,           // Host byte received.
   input  wire logic [7:0] rx_byte,            // Received byte value.
   input  wire logic       tx_ready,           // Link takes the offered byte.
   output logic            tx_valid,           // Response byte offered.
   output logic [7:0]      tx_byte,            // Response byte value.
   input  wire gtc_pins_t  pins,               // Pin input levels.
   input  wire logic       alt_detect_sel,     // Detect pin replaces pin C.
   input  wire logic       logic_supply_pin,   // Logic supply powered.
   input  wire logic       parasite_supply_on, // Parasite supply active.
   output logic            gpio_buf_en,        // Pin input buffer enable.
   input  wire logic       tmr_restart,        // Starts an arbitration timing run.
   output logic            tmr_expired,        // Arbitration time elapsed.
   output logic [7:0]      timeout_end_count   // Stored end count.
);

   gtc_core_t  s_q;
   gtc_core_t  s_d;
   logic [7:0] pin_byte;
   logic [2:0] lvl;
   logic [15:0] crc_cmd;

   function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d);
      logic [15:0] c;
      c = c_in;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ d[i]) begin
            c = (c >> 1) ^ `GTC_CRC_POLY_REFL; // R18
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   always_comb begin
      lvl = 3'b111;
      if (logic_supply_pin) begin // R2 R4
         lvl[`GTC_GPIO_A_BIT] = pins.gpio_pin_a;
         lvl[`GTC_GPIO_B_BIT] = pins.gpio_pin_b;
      end
      if (parasite_supply_on) begin // R3 R4
         lvl[`GTC_GPIO_C_BIT] = alt_detect_sel ? pins.alt_detect_pin : pins.gpio_pin_c; // R7
      end
      pin_byte = {1'b1, ~lvl, 1'b0, lvl}; // R6
   end

   assign crc_cmd = crc_byte(`GTC_CRC_SEED, rx_byte);

   always_comb begin
      s_d = s_q;
      if (link_reset) begin // R9
         s_d.st     = GTC_IDLE;
         s_d.buf_en = 1'b0;
      end else begin
         case (s_q.st)
            GTC_IDLE: begin
               if (rx_valid) begin
                  s_d.cmd = rx_byte;
                  s_d.crc = crc_cmd;
                  if (rx_byte == `GTC_CMD_GPIO_READ) begin
                     s_d.st     = GTC_SAMPLE; // R1
                     s_d.settle = 4'h0;
                     s_d.buf_en = 1'b1; // R5
                  end else if (rx_byte == `GTC_CMD_TEND_WRITE) begin
                     s_d.st = GTC_PARAM; // R10
                  end else if (rx_byte == `GTC_CMD_TEND_READ) begin
                     s_d.txb = s_q.tend; // R16
                     s_d.crc = crc_byte(crc_cmd, s_q.tend); // R17
                     s_d.st  = GTC_SEND_DATA;
                  end else begin
                     s_d.st = GTC_DONE;
                  end
               end
            end
            GTC_PARAM: begin
               if (rx_valid) begin
                  if (rx_byte == `GTC_TEND_REJECT) begin
                     s_d.st = GTC_DONE; // R12
                  end else begin
                     s_d.tend = rx_byte; // R10
                     s_d.crc  = crc_byte(s_q.crc, rx_byte); // R15
                     s_d.txb  = ~s_d.crc[7:0];
                     s_d.st   = GTC_SEND_CRC_LO;
                  end
               end
            end
            GTC_SAMPLE: begin
               if (s_q.settle == `GTC_SETTLE_CYC - 4'h1) begin
                  s_d.txb    = pin_byte; // R1
                  s_d.crc    = crc_byte(s_q.crc, pin_byte); // R8
                  s_d.buf_en = 1'b0; // R5
                  s_d.st     = GTC_SEND_DATA;
               end else begin
                  s_d.settle = s_q.settle + 4'h1;
               end
            end
            GTC_SEND_DATA: begin
               if (tx_ready) begin
                  s_d.txb = ~s_q.crc[7:0]; // R18
                  s_d.st  = GTC_SEND_CRC_LO;
               end
            end
            GTC_SEND_CRC_LO: begin
               if (tx_ready) begin
                  s_d.txb = ~s_q.crc[15:8]; // R18
                  s_d.st  = GTC_SEND_CRC_HI;
               end
            end
            GTC_SEND_CRC_HI: begin
               if (tx_ready) begin
                  s_d.st = GTC_DONE;
               end
            end
            default: begin
               s_d.st = GTC_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q      <= '0;
         s_q.st   <= GTC_IDLE;
         s_q.tend <= `GTC_TEND_RESET; // R13
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign tx_valid = (s_q.st == GTC_SEND_DATA) || (s_q.st == GTC_SEND_CRC_LO)
                     || (s_q.st == GTC_SEND_CRC_HI);
   assign tx_byte           = s_q.txb;
   assign gpio_buf_en       = s_q.buf_en;
   assign timeout_end_count = s_q.tend;

   gtc_timer #(
      .TICK_CYC (TICK_CYC)
   ) u_timer (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .restart   (tmr_restart),
      .end_count (s_q.tend), // R11
      .expired   (tmr_expired)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   logic step;
   assign step = clk_en && !link_reset;

   chk_tend_reset: assert property ($fell(sys_rst) |-> s_q.tend == `GTC_TEND_RESET) // R13
      else $error("End count not FFh after reset.");

   chk_reject_zero: assert property (step && s_q.st == GTC_PARAM && rx_valid // R12
      && rx_byte == 8'h00 |=> s_q.tend == $past(s_q.tend) && !tx_valid [*3])
      else $error("Zero end count was not rejected silently.");

   chk_write_store: assert property (step && s_q.st == GTC_PARAM && rx_valid // R10
      && rx_byte != 8'h00 |=> s_q.tend == $past(rx_byte) && tx_valid)
      else $error("Valid end count not stored or not answered.");

   chk_byte_form: assert property (tx_valid && s_q.st == GTC_SEND_DATA // R6
      && s_q.cmd == `GTC_CMD_GPIO_READ |-> tx_byte[7:4] == ~tx_byte[3:0] && !tx_byte[3])
      else $error("Pin byte lacks complement nibble.");

   chk_buf_off: assert property (s_q.st != GTC_SAMPLE |-> !gpio_buf_en) // R5
      else $error("Pin buffers enabled outside sampling.");

   chk_supply_high: assert property (step && s_q.st == GTC_SAMPLE // R2 R4
      && s_q.settle == `GTC_SETTLE_CYC - 4'h1 && !logic_supply_pin |=> tx_byte[1:0] == 2'b11)
      else $error("Unpowered pins A and B did not read high.");

   chk_alt_detect: assert property (step && s_q.st == GTC_SAMPLE // R7 R3
      && s_q.settle == `GTC_SETTLE_CYC - 4'h1 && alt_detect_sel && parasite_supply_on
      |=> tx_byte[2] == $past(pins.alt_detect_pin))
      else $error("Detect pin level not reported in pin C bit.");

   chk_read_tend: assert property (step && s_q.st == GTC_IDLE && rx_valid // R16
      && rx_byte == `GTC_CMD_TEND_READ |=> tx_valid && tx_byte == s_q.tend)
      else $error("Read end count did not return stored value.");

   chk_crc_follow: assert property (step && s_q.st == GTC_SEND_DATA && tx_ready // R8 R17
      |=> tx_valid && s_q.st == GTC_SEND_CRC_LO)
      else $error("Data byte not followed by the CRC low byte.");

   chk_crc_last: assert property (step && s_q.st == GTC_SEND_CRC_HI && tx_ready // R18
      |=> !tx_valid)
      else $error("Response went on after the CRC high byte.");

endmodule
`default_nettype wire

/* File: logic/gtc_timer.sv */
// Purpose: Arbitration timer counting 100 us ticks up to the end count.
// Assumes: end_count is never zero; restart clears the timer.
// Notes:   expired is a level that holds until the next restart.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_regs.svh"

module gtc_timer
   import gtc_pkg::*;
#(
   parameter int TICK_CYC = `GTC_TICK_CYC
) (
   input  wire logic       clk_sys,   // System clock.
   input  wire logic       sys_rst,   // Synchronous reset.
   input  wire logic       clk_en,    // Freezes state while low.
   input  wire logic       restart,   // Starts a new timing run.
   input  wire logic [7:0] end_count, // Duration in ticks.
   output logic            expired    // Duration has elapsed.
);

   gtc_tmr_t t_q;
   gtc_tmr_t t_d;

   always_comb begin
      t_d = t_q;
      if (restart) begin
         t_d = '0;
      end else if (!t_q.expired) begin
         if (t_q.pre == 16'(TICK_CYC - 1)) begin
            t_d.pre   = 16'h0000;
            t_d.ticks = t_q.ticks + 8'h01;
            if (t_q.ticks + 8'h01 == end_count) begin
               t_d.expired = 1'b1; // R11 R14
            end
         end else begin
            t_d.pre = t_q.pre + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         t_q <= '0;
      end else if (clk_en) begin
         t_q <= t_d;
      end
   end

   assign expired = t_q.expired;

   chk_tick_end: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
      $rose(t_q.expired) |-> t_q.ticks == end_count && t_q.pre == 16'h0000)
      else $error("Timer expired at a tick count other than the end count.");

endmodule
`default_nettype wire

/* File: sim/gpio_read_and_timeout_cmds_bench.sv */
// Purpose: Self-checking bench for the pin-read and timeout command block.
// Assumes: The host model sits on the byte link; clk_en drops only in the timer run.
// Notes:   The timer tick is shortened to TICK cycles.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_regs.svh"
module gpio_read_and_timeout_cmds_bench;
   import gtc_pkg::*;
   localparam int TICK = 4;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clk_en  = 1'b1;
   logic       alt_sel = 1'b0;
   logic       vl      = 1'b1;
   logic       ps      = 1'b1;
   logic       restart = 1'b0;
   gtc_pins_t  pins    = 4'hF;
   logic       link_reset, rx_valid, tx_ready, tx_valid, buf_en, expired;
   logic [7:0] rx_byte, tx_byte, tend;
   int         miscompares = 0;
   int         check_count = 0;
   int         tend_m      = 255;
   int         buf_cnt     = 0;

   gtc_host host (.clk_sys(clk_sys), .link_reset(link_reset), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte));
   gtc_cmd #(.TICK_CYC(TICK)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
      .link_reset(link_reset), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .pins(pins), .alt_detect_sel(alt_sel),
      .logic_supply_pin(vl), .parasite_supply_on(ps), .gpio_buf_en(buf_en),
      .tmr_restart(restart), .tmr_expired(expired), .timeout_end_count(tend));

   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (buf_en === 1'b1) buf_cnt++;
   initial begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      wrap_up();
   end

   task automatic wrap_up();
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic [15:0] crc16(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] c;
      logic [15:0] d;
      logic        fb;
      c = `GTC_CRC_SEED;
      d = {b, a};
      for (int k = 0; k < 16; k++) begin
         fb = c[0] ^ d[k];
         c = c >> 1;
         if (fb) c = c ^ `GTC_CRC_POLY_REFL;
      end
      return c;
   endfunction
   task automatic get(input string what, input logic [7:0] e);
      logic [7:0] g;
      bit         ok;
      host.recv(g, ok);
      if (!ok) begin
         cmp("response_present", 8'h01, 8'h00);
         wrap_up();
      end else begin
         cmp(what, e, g);
      end
   endtask
   task automatic run(input logic [7:0] cmd, input bit has_p, input logic [7:0] p,
                      input logic [7:0] data);
      logic [15:0] c;
      logic [7:0]  g;
      bit          ok;
      host.frame();
      host.send(cmd);
      if (has_p) host.send(p);
      c = ~crc16(cmd, has_p ? p : data);
      if (has_p && p == 8'h00) begin
         host.recv(g, ok);
         cmp("reject_silent", 8'h00, 8'(ok));
      end else begin
         if (has_p) tend_m = p;
         else get("data", data);
         get("crc_lo", c[7:0]);
         get("crc_hi", c[15:8]);
      end
      cmp("end_count", 8'(tend_m), tend);
   endtask

   initial begin
      logic [7:0] v;
      logic [3:0] lo;
      logic [7:0] g;
      bit         ok;
      int         n;
      void'($urandom(60));
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      cmp("end_count_reset", 8'hFF, tend);
      run(`GTC_CMD_TEND_READ, 0, 8'h00, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'h01 : 8'($urandom_range(255, 1));
         host.stall = i[0];
         run(`GTC_CMD_TEND_WRITE, 1, v, 8'h00);
         run(`GTC_CMD_TEND_READ, 0, 8'h00, 8'(tend_m));
      end
      run(`GTC_CMD_TEND_WRITE, 1, 8'h00, 8'h00);
      run(`GTC_CMD_TEND_READ, 0, 8'h00, 8'(tend_m));
      host.frame();
      host.send(8'h3C);
      host.recv(g, ok);
      cmp("unknown_silent", 8'h00, 8'(ok));
      for (int m = 0; m < 8; m++) begin
         @(negedge clk_sys);
         {ps, vl, alt_sel} = 3'(m);
         pins = 4'($urandom);
         host.stall = m[1];
         lo[0] = vl ? pins.gpio_pin_a : 1'b1;
         lo[1] = vl ? pins.gpio_pin_b : 1'b1;
         lo[2] = ps ? (alt_sel ? pins.alt_detect_pin : pins.gpio_pin_c) : 1'b1;
         lo[3] = 1'b0;
         buf_cnt = 0;
         run(`GTC_CMD_GPIO_READ, 0, 8'h00, {~lo, lo});
         cmp("buf_cycles", 8'h02, 8'(buf_cnt));
      end
      run(`GTC_CMD_TEND_WRITE, 1, 8'h03, 8'h00);
      @(negedge clk_sys);
      restart = 1'b1;
      @(negedge clk_sys);
      restart = 1'b0;
      clk_en = 1'b0;
      repeat (5) @(negedge clk_sys);
      clk_en = 1'b1;
      n = 5;
      while (expired !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      cmp("timer_cycles", 8'(tend_m * TICK + 5), 8'(n));
      sys_rst = 1'b1;
      @(negedge clk_sys);
      sys_rst = 1'b0;
      tend_m = 255;
      cmp("end_count_rereset", 8'hFF, tend);
      run(`GTC_CMD_TEND_READ, 0, 8'h00, 8'hFF);
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: sim/gtc_host.sv */
// Purpose: Host model that frames commands and takes response bytes.
// Assumes: Every change happens at the falling clock edge.
// Notes:   With stall set, random wait states come before each byte is taken.
`timescale 1ns/1ps
`default_nettype none
module gtc_host (
   input  wire logic       clk_sys,    // System clock.
   output logic            link_reset, // Frame restart.
   output logic            rx_valid,   // Byte strobe.
   output logic [7:0]      rx_byte,    // Byte value.
   output logic            tx_ready,   // Takes the offered byte.
   input  wire logic       tx_valid,   // Response byte offered.
   input  wire logic [7:0] tx_byte     // Response byte value.
);
   bit stall = 1'b0;
   initial begin
      link_reset = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end
   task automatic frame();
      @(negedge clk_sys);
      link_reset = 1'b1;
      @(negedge clk_sys);
      link_reset = 1'b0;
   endtask
   // The idle byte lines show the inverse so stale data is never mistaken for new.
   task automatic send(input logic [7:0] b);
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_byte = b;
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_byte = ~b;
   endtask
   task automatic recv(output logic [7:0] b, output bit ok);
      ok = 1'b0;
      b = 8'h00;
      if (stall) begin
         repeat ($urandom_range(3)) @(negedge clk_sys);
      end
      for (int i = 0; i < 40 && !ok; i++) begin
         @(negedge clk_sys);
         if (tx_valid === 1'b1) begin
            b = tx_byte;
            ok = 1'b1;
            tx_ready = 1'b1;
            @(negedge clk_sys);
            tx_ready = 1'b0;
         end
      end
   endtask
endmodule
`default_nettype wire
